// file: include/timer40_regs.svh
// Register offsets, field positions, reset values and divider counts for timer 40
`ifndef TIMER40_REGS_SVH
`define TIMER40_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TIMER40_MODE_ADDR 16'hff56
`define CARRIER_CTRL_ADDR 16'hff57
`define T40_COUNT_ADDR 16'hff58

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define TIMER40_MODE_RESET 8'h00
`define CARRIER_CTRL_RESET 8'h00
`define TIMER40_MODE_MASK 8'hbf
`define CARRIER_CTRL_MASK 8'h07

// ----------------------------------------
// Field positions
// ----------------------------------------
`define T40_ENABLE_BIT 7
`define T40_RESERVED_BIT 6
`define T40_CLOCK_SEL_LSB 3
`define T40_MODE_LSB 1
`define T40_OUT_ENABLE_BIT 0

// ----------------------------------------
// Count clock selection codes
// ----------------------------------------
`define CLK_SEL_SYS 3'h0
`define CLK_SEL_SYS_DIV4 3'h1
`define CLK_SEL_EXT 3'h2
`define CLK_SEL_EXT_DIV2 3'h3
`define CLK_SEL_EXT_DIV4 3'h4
`define CLK_SEL_EXT_DIV8 3'h5

// ----------------------------------------
// Divider counts
// ----------------------------------------
`define SYS_DIV4_LAST 2'h3
`define EXT_DIV2_MASK 3'h1
`define EXT_DIV4_MASK 3'h3
`define EXT_DIV8_MASK 3'h7

`endif

// file: include/timer40_pkg.sv
// Types shared by the timer 40 control and carrier output logic
package timer40_pkg;

  // ----------------------------------------
  // Register layouts
  // ----------------------------------------
  typedef struct packed {
    logic t40_count_enable;
    logic reserved;
    logic [2:0] t40_clock_sel;
    logic [1:0] t40_mode;
    logic timer_output_enable;
  } mode_ctrl_type;

  typedef struct packed {
    logic [4:0] reserved;
    logic remote_level_select;
    logic next_output_data_buffer;
    logic output_data_bit;
  } carrier_ctrl_type;

  // ----------------------------------------
  // Operating modes and carrier phase
  // ----------------------------------------
  typedef enum logic [3:0] {
    MODE_DISCRETE = 4'h1,
    MODE_CASCADE = 4'h2,
    MODE_CARRIER = 4'h4,
    MODE_PWM = 4'h8
  } op_mode_type;

  typedef enum logic [1:0] {
    PHASE_LOW = 2'h1,
    PHASE_HIGH = 2'h2
  } phase_type;

endpackage : timer40_pkg

// file: design/count_clock_select.sv
// Count clock tick generator: system clock prescaler and synchronised timer input
`timescale 1ns/1ps
`include "timer40_regs.svh"

module count_clock_select (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic [2:0] clock_sel_i,
  input wire logic timer_input_pin_i,
  output logic tick_o
);

  logic sync_a;
  logic sync_b;
  logic pin_prev;
  logic [1:0] sys_div;
  logic [2:0] ext_div;
  logic next_sync_a;
  logic next_sync_b;
  logic next_pin_prev;
  logic [1:0] next_sys_div;
  logic [2:0] next_ext_div;
  logic ext_edge;

  // ----------------------------------------
  // Tick selection
  // ----------------------------------------
  always_comb begin
    ext_edge = sync_b & ~pin_prev;
    next_sync_a = timer_input_pin_i;
    next_sync_b = sync_a;
    next_pin_prev = sync_b;
    next_sys_div = run_i ? sys_div + 2'h1 : 2'h0;
    next_ext_div = ext_div;
    if (!run_i) begin
      next_ext_div = 3'h0;
    end else if (ext_edge) begin
      next_ext_div = ext_div + 3'h1;
    end
    unique case (clock_sel_i)
      `CLK_SEL_SYS: tick_o = run_i;
      `CLK_SEL_SYS_DIV4: tick_o = run_i & (sys_div == `SYS_DIV4_LAST);
      `CLK_SEL_EXT: tick_o = run_i & ext_edge;
      `CLK_SEL_EXT_DIV2: tick_o = run_i & ext_edge & ((ext_div & `EXT_DIV2_MASK) == `EXT_DIV2_MASK);
      `CLK_SEL_EXT_DIV4: tick_o = run_i & ext_edge & ((ext_div & `EXT_DIV4_MASK) == `EXT_DIV4_MASK);
      `CLK_SEL_EXT_DIV8: tick_o = run_i & ext_edge & ((ext_div & `EXT_DIV8_MASK) == `EXT_DIV8_MASK);
      default: tick_o = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      pin_prev <= 1'b0;
      sys_div <= 2'h0;
      ext_div <= 3'h0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      pin_prev <= next_pin_prev;
      sys_div <= next_sys_div;
      ext_div <= next_ext_div;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_sys_clock_tick: assert property (@(posedge clk_i) disable iff (reset_i)
    (run_i && clock_sel_i == `CLK_SEL_SYS) |-> tick_o)
    else $error("System clock selection did not tick every cycle");

  a_div4_spacing: assert property (@(posedge clk_i) disable iff (reset_i)
    (tick_o && clock_sel_i == `CLK_SEL_SYS_DIV4 && run_i) |=>
    (!tick_o || clock_sel_i != `CLK_SEL_SYS_DIV4 || !run_i) [*3])
    else $error("Divide by four tick came early");

endmodule : count_clock_select

// file: design/timer_output_stage.sv
// Timer output pin driver: selects carrier, level or square wave and gates by enable
`timescale 1ns/1ps

module timer_output_stage (
  input wire logic clk_i,
  input wire logic reset_i,
  input timer40_pkg::op_mode_type mode_i,
  input wire logic out_enable_i,
  input wire logic data_bit_i,
  input wire logic remote_i,
  input wire logic carrier_i,
  input wire logic square_i,
  output logic pin_o,
  output logic oe_o
);

  logic next_pin;
  logic level;

  // ----------------------------------------
  // Output level
  // ----------------------------------------
  always_comb begin
    unique case (mode_i)
      timer40_pkg::MODE_CARRIER: level = data_bit_i & (remote_i | carrier_i);
      timer40_pkg::MODE_PWM: level = carrier_i;
      timer40_pkg::MODE_DISCRETE, timer40_pkg::MODE_CASCADE: level = square_i;
      default: level = 1'b0;
    endcase
    next_pin = out_enable_i & level;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_o <= 1'b0;
      oe_o <= 1'b0;
    end else begin
      pin_o <= next_pin;
      oe_o <= out_enable_i;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_output_disabled: assert property (@(posedge clk_i) disable iff (reset_i)
    !out_enable_i |=> (!pin_o && !oe_o))
    else $error("Timer output driven while disabled");

  a_low_when_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    (mode_i == timer40_pkg::MODE_CARRIER && !data_bit_i) |=> !pin_o)
    else $error("Timer output not low with data bit clear");

  a_remote_high: assert property (@(posedge clk_i) disable iff (reset_i)
    (mode_i == timer40_pkg::MODE_CARRIER && out_enable_i && data_bit_i && remote_i) |=> pin_o)
    else $error("Timer output not high in remote level mode");

endmodule : timer_output_stage

// file: design/timer40_control_carrier_output.sv
// Timer 40 mode control, counter, carrier generator and output data control
`timescale 1ns/1ps
`include "timer40_regs.svh"

// How it works
// - Count enable low clears counter 40 and, in cascade, counter 30 too
// - Count enable high starts counting, and starts timer 30 in cascade
// - In cascade, timer 30 own enable is ignored; timer 40 enable rules
// - Clock select bits 5..3 pick system, system/4, external, external/2/4/8
// - Mode decoded from timer 30 and timer 40 mode pairs; others prohibited, but all other pairs decode to discrete
// - Bit 0 enables the timer output onto the pin
// - Mode register takes bit or byte writes, resets to 00H
// - Data bit one: carrier pulse, or steady high when remote bit set
// - Data bit zero: output low and carrier clock stopped
// - Buffered data bit copies into data bit on timer 30 match rising edge
// - Software writes to data bit only land while output disabled
// - Buffered data bit is lost when the carrier generator stops
// - Carrier control register resets to 00H
// - External clock choices come from the timer input pin
// - Low compare sets low width in carrier and PWM modes
// - High compare sets high width and raises interrupt on match
module timer40_control_carrier_output (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic bit_write_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic bit_value_i,
  output logic [7:0] rdata_o,
  input wire logic [1:0] t30_mode_i,
  input wire logic t30_count_enable_i,
  input wire logic timer30_match_i,
  input wire logic timer_input_pin_i,
  input wire logic [7:0] timer40_low_compare_i,
  input wire logic [7:0] timer40_high_compare_i,
  output logic timer_output_pin_o,
  output logic timer_output_oe_o,
  output logic [7:0] timer40_counter_o,
  output logic timer40_irq_o,
  output logic t30_run_o,
  output logic t30_clear_o,
  output logic carrier_clock_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic timer40_pkg::op_mode_type decode_mode(input logic [1:0] t30,
                                                           input logic [1:0] t40);
    timer40_pkg::op_mode_type m;
    unique case ({t30, t40})
      4'h5: m = timer40_pkg::MODE_CASCADE;
      4'h3: m = timer40_pkg::MODE_CARRIER;
      4'h2: m = timer40_pkg::MODE_PWM;
      default: m = timer40_pkg::MODE_DISCRETE;
    endcase
    return m;
  endfunction : decode_mode

  function automatic logic hit(input logic [7:0] count, input logic [7:0] compare);
    return count == compare;
  endfunction : hit

  timer40_pkg::mode_ctrl_type mode_ctrl;
  timer40_pkg::carrier_ctrl_type carrier_ctrl;
  timer40_pkg::mode_ctrl_type next_mode_ctrl;
  timer40_pkg::carrier_ctrl_type next_carrier_ctrl;
  timer40_pkg::op_mode_type mode;
  timer40_pkg::phase_type phase;
  timer40_pkg::phase_type next_phase;
  logic match_prev;
  logic run_prev;
  logic carrier_run;
  logic match_rise;
  logic [7:0] next_rdata;
  logic [7:0] mode_bits;
  logic [7:0] next_counter;
  logic next_irq;
  logic next_square;
  logic square;
  logic next_t30_run;
  logic next_t30_clear;
  logic next_carrier_clock;
  logic tick;
  logic mode_write;
  logic carrier_write;

  assign mode = decode_mode(t30_mode_i, mode_ctrl.t40_mode);
  assign carrier_run = mode_ctrl.t40_count_enable && mode == timer40_pkg::MODE_CARRIER;
  assign match_rise = timer30_match_i & ~match_prev;
  assign mode_write = write_i && addr_i == `TIMER40_MODE_ADDR;
  assign carrier_write = write_i && addr_i == `CARRIER_CTRL_ADDR;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_comb begin
    next_mode_ctrl = mode_ctrl;
    next_carrier_ctrl = carrier_ctrl;
    mode_bits = mode_ctrl;
    if (mode_write) begin
      next_mode_ctrl = timer40_pkg::mode_ctrl_type'(wdata_i & `TIMER40_MODE_MASK);
    end else if (bit_write_i && addr_i == `TIMER40_MODE_ADDR) begin
      mode_bits[bit_sel_i] = bit_value_i;
      next_mode_ctrl = timer40_pkg::mode_ctrl_type'(mode_bits & `TIMER40_MODE_MASK);
    end
    if (run_prev && !carrier_run) begin
      next_carrier_ctrl.next_output_data_buffer = 1'b0;
    end
    if (carrier_write) begin
      next_carrier_ctrl.remote_level_select = wdata_i[2];
      next_carrier_ctrl.next_output_data_buffer = wdata_i[1];
      if (!mode_ctrl.timer_output_enable) begin
        next_carrier_ctrl.output_data_bit = wdata_i[0];
      end
    end
    if (match_rise) begin
      next_carrier_ctrl.output_data_bit = carrier_ctrl.next_output_data_buffer;
    end
    next_carrier_ctrl.reserved = 5'h00;
    unique case (1'b1)
      read_i && addr_i == `TIMER40_MODE_ADDR: next_rdata = mode_ctrl;
      read_i && addr_i == `T40_COUNT_ADDR: next_rdata = timer40_counter_o;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_ctrl <= timer40_pkg::mode_ctrl_type'(`TIMER40_MODE_RESET);
      carrier_ctrl <= timer40_pkg::carrier_ctrl_type'(`CARRIER_CTRL_RESET);
      match_prev <= 1'b0;
      run_prev <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      mode_ctrl <= next_mode_ctrl;
      carrier_ctrl <= next_carrier_ctrl;
      match_prev <= timer30_match_i;
      run_prev <= carrier_run;
      rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------
  // Count clock
  // ----------------------------------------
  count_clock_select u_clock_select (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .run_i(mode_ctrl.t40_count_enable),
    .clock_sel_i(mode_ctrl.t40_clock_sel),
    .timer_input_pin_i(timer_input_pin_i),
    .tick_o(tick)
  );

  // ----------------------------------------
  // Counter and carrier phase
  // ----------------------------------------
  always_comb begin
    next_counter = timer40_counter_o;
    next_phase = phase;
    next_irq = 1'b0;
    next_square = square;
    next_t30_run = (mode == timer40_pkg::MODE_CASCADE) ?
                   mode_ctrl.t40_count_enable : t30_count_enable_i;
    next_t30_clear = (mode == timer40_pkg::MODE_CASCADE) &&
                     !mode_ctrl.t40_count_enable;
    if (!mode_ctrl.t40_count_enable) begin
      next_counter = 8'h00;
      next_phase = timer40_pkg::PHASE_LOW;
    end else if (tick) begin
      next_counter = timer40_counter_o + 8'h01;
      unique case (mode)
        timer40_pkg::MODE_CARRIER, timer40_pkg::MODE_PWM: begin
          if (phase == timer40_pkg::PHASE_LOW) begin
            if (hit(timer40_counter_o, timer40_low_compare_i)) begin
              next_counter = 8'h00;
              next_phase = timer40_pkg::PHASE_HIGH;
            end
          end else if (hit(timer40_counter_o, timer40_high_compare_i)) begin
            next_counter = 8'h00;
            next_phase = timer40_pkg::PHASE_LOW;
            next_irq = 1'b1;
          end
        end
        timer40_pkg::MODE_CASCADE: begin
          if (hit(timer40_counter_o, timer40_low_compare_i) && timer30_match_i) begin
            next_counter = 8'h00;
            next_irq = 1'b1;
          end
        end
        timer40_pkg::MODE_DISCRETE: begin
          if (hit(timer40_counter_o, timer40_low_compare_i)) begin
            next_counter = 8'h00;
            next_irq = 1'b1;
            next_square = ~square;
          end
        end
      endcase
    end
    next_carrier_clock = (phase == timer40_pkg::PHASE_HIGH) &&
                         (mode != timer40_pkg::MODE_CARRIER ||
                          carrier_ctrl.output_data_bit);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      timer40_counter_o <= 8'h00;
      phase <= timer40_pkg::PHASE_LOW;
      timer40_irq_o <= 1'b0;
      square <= 1'b0;
      t30_run_o <= 1'b0;
      t30_clear_o <= 1'b0;
      carrier_clock_o <= 1'b0;
    end else begin
      timer40_counter_o <= next_counter;
      phase <= next_phase;
      timer40_irq_o <= next_irq;
      square <= next_square;
      t30_run_o <= next_t30_run;
      t30_clear_o <= next_t30_clear;
      carrier_clock_o <= next_carrier_clock;
    end
  end

  // ----------------------------------------
  // Output pin
  // ----------------------------------------
  timer_output_stage u_output_stage (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .mode_i(mode),
    .out_enable_i(mode_ctrl.timer_output_enable),
    .data_bit_i(carrier_ctrl.output_data_bit),
    .remote_i(carrier_ctrl.remote_level_select),
    .carrier_i(phase == timer40_pkg::PHASE_HIGH),
    .square_i(square),
    .pin_o(timer_output_pin_o),
    .oe_o(timer_output_oe_o)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_match_rise;
    !timer30_match_i ##1 timer30_match_i;
  endsequence

  sequence s_carrier_stop;
    carrier_run ##1 !carrier_run;
  endsequence

  a_disable_clears: assert property (
    !mode_ctrl.t40_count_enable |=> (timer40_counter_o == 8'h00 && phase == timer40_pkg::PHASE_LOW))
    else $error("Counter not cleared while count enable low");

  a_cascade_clear: assert property (
    (mode == timer40_pkg::MODE_CASCADE && !mode_ctrl.t40_count_enable) |=> t30_clear_o)
    else $error("Timer 30 not cleared in cascade stop");

  a_cascade_follow: assert property (
    mode == timer40_pkg::MODE_CASCADE |=> t30_run_o == $past(mode_ctrl.t40_count_enable))
    else $error("Timer 30 run not following timer 40 enable in cascade");

  a_count_step: assert property (
    (mode_ctrl.t40_count_enable && tick && mode == timer40_pkg::MODE_DISCRETE &&
     !hit(timer40_counter_o, timer40_low_compare_i) && !mode_write && !bit_write_i) |=>
    timer40_counter_o == $past(timer40_counter_o) + 8'h01)
    else $error("Counter did not advance on count tick");

  a_mode_byte_write: assert property (
    mode_write |=> mode_ctrl == ($past(wdata_i) & `TIMER40_MODE_MASK))
    else $error("Mode register byte write not stored");

  a_data_copy: assert property (
    s_match_rise |=> carrier_ctrl.output_data_bit == $past(carrier_ctrl.next_output_data_buffer))
    else $error("Data bit not loaded on timer 30 match");

  a_data_locked: assert property (
    (carrier_write && mode_ctrl.timer_output_enable && !match_rise) |=>
    $stable(carrier_ctrl.output_data_bit))
    else $error("Data bit changed by write while output enabled");

  a_buffer_lost: assert property (
    s_carrier_stop and (##1 !carrier_write) |=> !carrier_ctrl.next_output_data_buffer)
    else $error("Buffered data kept across carrier stop");

  a_high_irq: assert property (
    (mode_ctrl.t40_count_enable && tick && phase == timer40_pkg::PHASE_HIGH &&
     mode == timer40_pkg::MODE_PWM && hit(timer40_counter_o, timer40_high_compare_i)) |=>
    (timer40_irq_o && phase == timer40_pkg::PHASE_LOW && timer40_counter_o == 8'h00))
    else $error("High compare match did not end high phase with interrupt");

endmodule : timer40_control_carrier_output

// file: testbench/timer40_control_carrier_output_test.sv
// Self-checking bench for the timer 40 control and carrier output block
`timescale 1ns/1ps
`include "timer40_regs.svh"

module timer40_control_carrier_output_test;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic write_i = 1'b0;
  logic read_i = 1'b0;
  logic bit_write_i = 1'b0;
  logic [2:0] bit_sel_i = 3'h0;
  logic bit_value_i = 1'b0;
  logic [1:0] t30_mode_i = 2'h0;
  logic t30_count_enable_i = 1'b0;
  logic timer30_match_i = 1'b0;
  logic timer_input_pin_i = 1'b0;
  logic [7:0] timer40_low_compare_i = 8'hff;
  logic [7:0] timer40_high_compare_i = 8'hff;
  logic [7:0] rdata_o;
  logic timer_output_pin_o;
  logic timer_output_oe_o;
  logic [7:0] timer40_counter_o;
  logic timer40_irq_o;
  logic t30_run_o;
  logic t30_clear_o;
  logic carrier_clock_o;
  logic [2:0] ext_cnt = 3'h0;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  int seed = 18846;
  logic [7:0] v;
  logic lo_seen, hi_seen, ck_seen;
  int irq_n = 0;

  timer40_control_carrier_output timer40_control_carrier_output_inst (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .bit_write_i(bit_write_i),
    .bit_sel_i(bit_sel_i), .bit_value_i(bit_value_i), .rdata_o(rdata_o),
    .t30_mode_i(t30_mode_i), .t30_count_enable_i(t30_count_enable_i),
    .timer30_match_i(timer30_match_i), .timer_input_pin_i(timer_input_pin_i),
    .timer40_low_compare_i(timer40_low_compare_i),
    .timer40_high_compare_i(timer40_high_compare_i),
    .timer_output_pin_o(timer_output_pin_o), .timer_output_oe_o(timer_output_oe_o),
    .timer40_counter_o(timer40_counter_o), .timer40_irq_o(timer40_irq_o),
    .t30_run_o(t30_run_o), .t30_clear_o(t30_clear_o),
    .carrier_clock_o(carrier_clock_o)
  );

  // ----------------------------------------
  // Clock, external input clock, read monitor
  // ----------------------------------------
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    ext_cnt <= ext_cnt + 3'h1;
    timer_input_pin_i <= ext_cnt[2];
    rd_d <= read_i;
  end

  always @(negedge clk_i) begin
    if (rd_d === 1'b1) begin
      check("rdata", rdata_o, exp_q.pop_front());
    end
  end

  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clk_i);
    write_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    read_i <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clk_i);
    read_i <= 1'b0;
  endtask : rd

  task automatic bw(input logic [2:0] s, input logic b);
    @(posedge clk_i);
    addr_i <= `TIMER40_MODE_ADDR;
    bit_sel_i <= s;
    bit_value_i <= b;
    bit_write_i <= 1'b1;
    @(posedge clk_i);
    bit_write_i <= 1'b0;
  endtask : bw

  task automatic settle();
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  task automatic match30();
    @(posedge clk_i);
    timer30_match_i <= 1'b1;
    @(posedge clk_i);
    timer30_match_i <= 1'b0;
    settle();
  endtask : match30

  task automatic rate(input logic [2:0] sel, input int exp);
    int n;
    logic [7:0] prev;
    wr(`TIMER40_MODE_ADDR, {1'b1, 1'b0, sel, 3'h0});
    repeat (30) @(posedge clk_i);
    @(negedge clk_i);
    n = 0;
    prev = timer40_counter_o;
    repeat (160) begin
      @(negedge clk_i);
      if (timer40_counter_o !== prev) n++;
      prev = timer40_counter_o;
    end
    check("tick rate", 8'((n >= exp - 1) && (n <= exp + 1)), 8'h01);
    wr(`TIMER40_MODE_ADDR, 8'h00);
    settle();
    check("counter clear", timer40_counter_o, 8'h00);
  endtask : rate

  task automatic watch();
    lo_seen = 1'b0;
    hi_seen = 1'b0;
    ck_seen = 1'b0;
    irq_n = 0;
    repeat (40) begin
      @(negedge clk_i);
      if (timer_output_pin_o === 1'b0) lo_seen = 1'b1;
      if (timer_output_pin_o === 1'b1) hi_seen = 1'b1;
      if (carrier_clock_o === 1'b1) ck_seen = 1'b1;
      if (timer40_irq_o === 1'b1) irq_n++;
    end
  endtask : watch

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    settle();
    check("pin reset", {7'h0, timer_output_pin_o}, 8'h00);
    rd(`TIMER40_MODE_ADDR, `TIMER40_MODE_RESET);
    rd(`CARRIER_CTRL_ADDR, 8'h00);
    rd(16'hff59, 8'h00);
    repeat (8) begin
      v = 8'($random(seed)) & `TIMER40_MODE_MASK;
      if (v[2:1] == 2'h1) v[1] = 1'b0;
      wr(`TIMER40_MODE_ADDR, v);
      rd(`TIMER40_MODE_ADDR, v & `TIMER40_MODE_MASK);
    end
    wr(`TIMER40_MODE_ADDR, 8'h00);
    bw(3'h0, 1'b1);
    bw(3'h5, 1'b1);
    rd(`TIMER40_MODE_ADDR, 8'h21);
    check("oe on", {7'h0, timer_output_oe_o}, 8'h01);
    bw(3'h0, 1'b0);
    rd(`TIMER40_MODE_ADDR, 8'h20);
    check("oe off", {7'h0, timer_output_oe_o}, 8'h00);
    wr(`TIMER40_MODE_ADDR, 8'h00);
    rate(`CLK_SEL_SYS, 160);
    rate(`CLK_SEL_SYS_DIV4, 40);
    rate(`CLK_SEL_EXT, 20);
    rate(`CLK_SEL_EXT_DIV2, 10);
    rate(`CLK_SEL_EXT_DIV4, 5);
    rate(`CLK_SEL_EXT_DIV8, 2);
    rd(`T40_COUNT_ADDR, 8'h00);
    t30_mode_i <= 2'h1;
    t30_count_enable_i <= 1'b1;
    wr(`TIMER40_MODE_ADDR, 8'h02);
    settle();
    check("t30 run held", {7'h0, t30_run_o}, 8'h00);
    check("t30 clear", {7'h0, t30_clear_o}, 8'h01);
    wr(`TIMER40_MODE_ADDR, 8'h82);
    settle();
    check("t30 run", {7'h0, t30_run_o}, 8'h01);
    check("t30 clear off", {7'h0, t30_clear_o}, 8'h00);
    wr(`TIMER40_MODE_ADDR, 8'h00);
    t30_mode_i <= 2'h0;
    t30_count_enable_i <= 1'b0;
    timer40_low_compare_i <= 8'h02;
    timer40_high_compare_i <= 8'h02;
    wr(`TIMER40_MODE_ADDR, 8'h06);
    wr(`CARRIER_CTRL_ADDR, 8'h01);
    wr(`TIMER40_MODE_ADDR, 8'h87);
    settle();
    watch();
    check("carrier pulse", {6'h0, lo_seen, hi_seen}, 8'h03);
    check("carrier clock", {7'h0, ck_seen}, 8'h01);
    check("carrier irq", 8'((irq_n >= 6) && (irq_n <= 7)), 8'h01);
    wr(`CARRIER_CTRL_ADDR, 8'h04);
    settle();
    check("data bit kept", {7'h0, timer_output_pin_o}, 8'h01);
    match30();
    check("pin low", {7'h0, timer_output_pin_o}, 8'h00);
    watch();
    check("clock stopped", {7'h0, ck_seen}, 8'h00);
    wr(`CARRIER_CTRL_ADDR, 8'h06);
    match30();
    check("pin high", {7'h0, timer_output_pin_o}, 8'h01);
    wr(`TIMER40_MODE_ADDR, 8'h07);
    settle();
    wr(`TIMER40_MODE_ADDR, 8'h87);
    match30();
    check("buffer lost", {7'h0, timer_output_pin_o}, 8'h00);
    wr(`TIMER40_MODE_ADDR, 8'h00);
    wr(`TIMER40_MODE_ADDR, 8'h85);
    settle();
    watch();
    check("pwm pulse", {5'h0, ck_seen, lo_seen, hi_seen}, 8'h07);
    check("pwm irq", 8'((irq_n >= 6) && (irq_n <= 7)), 8'h01);
    wr(`TIMER40_MODE_ADDR, 8'h00);
    wr(`TIMER40_MODE_ADDR, 8'h81);
    settle();
    watch();
    check("square wave", {6'h0, lo_seen, hi_seen}, 8'h03);
    check("interval irq", 8'((irq_n >= 13) && (irq_n <= 14)), 8'h01);
    tally_and_finish();
  end
endmodule : timer40_control_carrier_output_test
